/* core/logical_address_generation.sv */
// segment registers, descriptor cache and operand address generation
`timescale 1ns/100ps
`default_nettype none
module logical_address_generation
	import lag_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              srst_i,
	// selector load from a program instruction
	input  wire logic              sel_wr_i,
	input  wire logic [SEGI_W-1:0] sel_wr_idx_i,
	input  wire logic [SEL_W-1:0]  sel_wr_val_i,
	// descriptor fetch port toward the bus unit
	output logic                   desc_req_o,
	output logic [SEL_W-1:0]       desc_sel_o,
	input  wire logic              desc_ack_i,
	input  wire logic [31:0]       desc_base_i,
	output logic                   load_busy_o,
	// general registers, pointers
	input  wire logic [NGPR*32-1:0] gpr_i,
	input  wire logic [31:0]       instruction_pointer_reg_i,
	input  wire logic [31:0]       stack_pointer_reg_i,
	// override prefix from the decoder
	input  wire logic              prefix_i,
	input  wire logic [SEGI_W-1:0] prefix_seg_i,
	// translation request
	input  wire logic              xlat_req_i,
	input  wire acc_kind_t         acc_kind_i,
	input  wire op_size_t          op_size_i,
	input  wire logic              use_base_i,
	input  wire logic [GPR_W-1:0]  base_sel_i,
	input  wire logic              use_index_i,
	input  wire logic [GPR_W-1:0]  index_sel_i,
	input  wire logic [1:0]        scale_log_i,
	input  wire logic              use_disp_i,
	input  wire logic              disp_wide_i,
	input  wire logic [31:0]       disp_i,
	// results
	output logic                   addr_vld_o,
	output logic [ADDR_W-1:0]      addr_o,
	output logic [ADDR_W-1:0]      near_ptr_o,
	output logic [FAR_W-1:0]       far_ptr_o,
	output logic [SEGI_W-1:0]      seg_used_o,
	output logic                   misaligned_o,
	output logic [SEL_W-1:0]       data_segment_selector_a_o,
	output logic [SEL_W-1:0]       data_segment_selector_b_o,
	output logic [SEL_W-1:0]       data_segment_selector_c_o,
	output logic [SEL_W-1:0]       data_segment_selector_d_o
);
	// visible selectors and hidden descriptor bases
	logic [SEL_W-1:0]  sel_ff      [NSEG];
	logic [SEL_W-1:0]  nxt_sel     [NSEG];
	logic [31:0]       desc_ff     [NSEG];
	logic [31:0]       nxt_desc    [NSEG];
	ld_state_t         ld_ff, nxt_ld;
	logic [SEGI_W-1:0] ld_idx_ff, nxt_ld_idx;
	logic              pend_ff, nxt_pend;
	logic [SEGI_W-1:0] pend_seg_ff, nxt_pend_seg;
	logic              vld_ff, nxt_vld;
	logic [31:0]       addr_ff, nxt_addr, off_ff, nxt_off;
	logic [SEGI_W-1:0] used_ff, nxt_used;
	logic              mis_ff, nxt_mis;
	logic [SEGI_W-1:0] seg_sel;
	logic [31:0]       lin_off;
	logic [3:0]        size_mask;
	logic              req_ff, nxt_req;
	logic              busy_ff, nxt_busy;
	logic [SEL_W-1:0]  ld_sel_ff, nxt_ld_sel;
	logic [SEL_W-1:0]  far_sel_ff, nxt_far_sel;

	offset_if oi ();
	offset_adder u_adder (
		.oi (oi.calc)
	);

	// operand fields: any general register as base or index
	assign oi.base_val  = gpr_i[base_sel_i*32 +: 32];
	assign oi.index_val = gpr_i[index_sel_i*32 +: 32];
	assign oi.scale_log = scale_log_i;
	assign oi.disp_val  = disp_i;
	assign oi.disp_wide = disp_wide_i;
	// mode set by use bits covers direct through based indexed with disp
	assign oi.use_base  = use_base_i;
	assign oi.use_index = use_index_i;
	assign oi.use_disp  = use_disp_i;

	// descriptor load: selector write starts a fetch of its descriptor
	always_comb begin
		nxt_ld     = ld_ff;
		nxt_ld_idx = ld_idx_ff;
		nxt_ld_sel = ld_sel_ff;
		for (int i = 0; i < NSEG; i++) begin
			nxt_sel[i]  = sel_ff[i];
			nxt_desc[i] = desc_ff[i];
		end
		unique case (ld_ff)
			LD_IDLE: begin
				if (sel_wr_i) begin
					nxt_sel[sel_wr_idx_i] = sel_wr_val_i;
					nxt_ld_idx            = sel_wr_idx_i;
					nxt_ld_sel            = sel_wr_val_i;
					nxt_ld                = LD_REQ;
				end
			end
			LD_REQ: begin
				nxt_ld = LD_WAIT;
			end
			LD_WAIT: begin
				if (desc_ack_i) begin
					nxt_desc[ld_idx_ff] = desc_base_i;
					nxt_ld              = LD_IDLE;
				end
			end
			default: begin
				nxt_ld = LD_IDLE;
			end
		endcase
		// request and busy registered so both ports come from flops
		nxt_req  = (nxt_ld == LD_WAIT);
		nxt_busy = (nxt_ld != LD_IDLE);
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ld_ff     <= LD_IDLE;
			ld_idx_ff <= SEG_CODE;
			req_ff    <= 1'b0;
			busy_ff   <= 1'b0;
			ld_sel_ff <= SEL_RST;
			for (int i = 0; i < NSEG; i++) begin
				sel_ff[i]  <= SEL_RST;
				desc_ff[i] <= DESC_BASE_RST;
			end
		end else begin
			ld_ff     <= nxt_ld;
			ld_idx_ff <= nxt_ld_idx;
			req_ff    <= nxt_req;
			busy_ff   <= nxt_busy;
			ld_sel_ff <= nxt_ld_sel;
			for (int i = 0; i < NSEG; i++) begin
				sel_ff[i]  <= nxt_sel[i];
				desc_ff[i] <= nxt_desc[i];
			end
		end
	end

	// segment choice: pending prefix overrides the implicit one for data accesses only
	always_comb begin
		unique case (acc_kind_i)
			ACC_FETCH: seg_sel = SEG_CODE;
			ACC_JUMP:  seg_sel = SEG_CODE;
			ACC_STACK: seg_sel = SEG_STACK;
			ACC_DATA:  seg_sel = SEG_DATA_A;
		endcase
		if (pend_ff && acc_kind_i == ACC_DATA) begin
			seg_sel = pend_seg_ff;
		end
		unique case (acc_kind_i)
			ACC_FETCH: lin_off = instruction_pointer_reg_i;
			ACC_STACK: lin_off = stack_pointer_reg_i;
			ACC_DATA:  lin_off = oi.offset;
			ACC_JUMP:  lin_off = oi.offset;
		endcase
		unique case (op_size_i)
			SZ_BYTE:  size_mask = 4'h0;
			SZ_WORD:  size_mask = 4'h1;
			SZ_DWORD: size_mask = 4'h3;
			SZ_FAR:   size_mask = 4'h1;
		endcase
	end

	// prefix held until the next translated instruction consumes it
	always_comb begin
		nxt_pend     = pend_ff;
		nxt_pend_seg = pend_seg_ff;
		if (xlat_req_i && ld_ff == LD_IDLE && !sel_wr_i) begin
			nxt_pend = 1'b0;
		end
		if (prefix_i) begin
			nxt_pend     = 1'b1;
			nxt_pend_seg = prefix_seg_i;
		end
	end

	// translation result; uses cached descriptor, refuses requests during a load or a selector write
	always_comb begin
		nxt_vld  = 1'b0;
		nxt_addr = addr_ff;
		nxt_off  = off_ff;
		nxt_used = used_ff;
		nxt_mis  = mis_ff;
		nxt_far_sel = far_sel_ff;
		if (xlat_req_i && ld_ff == LD_IDLE && !sel_wr_i) begin
			nxt_vld  = 1'b1;
			nxt_off  = lin_off;
			nxt_addr = 32'(desc_ff[seg_sel] + lin_off);
			nxt_used = seg_sel;
			nxt_far_sel = sel_ff[seg_sel];
			nxt_mis  = |(lin_off[3:0] & size_mask);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pend_ff     <= 1'b0;
			pend_seg_ff <= SEG_DATA_A;
			vld_ff      <= 1'b0;
			addr_ff     <= 32'h0000_0000;
			off_ff      <= 32'h0000_0000;
			used_ff     <= SEG_CODE;
			mis_ff      <= 1'b0;
			far_sel_ff  <= SEL_RST;
		end else begin
			pend_ff     <= nxt_pend;
			pend_seg_ff <= nxt_pend_seg;
			vld_ff      <= nxt_vld;
			addr_ff     <= nxt_addr;
			off_ff      <= nxt_off;
			used_ff     <= nxt_used;
			mis_ff      <= nxt_mis;
			far_sel_ff  <= nxt_far_sel;
		end
	end

	// outputs straight from flops
	assign desc_req_o   = req_ff;
	assign desc_sel_o   = ld_sel_ff;
	assign load_busy_o  = busy_ff;
	assign addr_vld_o   = vld_ff;
	assign addr_o       = addr_ff;
	assign near_ptr_o   = off_ff;
	assign far_ptr_o    = {far_sel_ff, off_ff};
	assign seg_used_o   = used_ff;
	assign misaligned_o = mis_ff;
	assign data_segment_selector_a_o = sel_ff[SEG_DATA_A];
	assign data_segment_selector_b_o = sel_ff[SEG_DATA_B];
	assign data_segment_selector_c_o = sel_ff[SEG_DATA_C];
	assign data_segment_selector_d_o = sel_ff[SEG_DATA_D];
endmodule
`default_nettype wire

/* core/lag_pkg.sv */
// constants and types for logical address generation
// How it works
// - six selectors, each with hidden descriptor
// - selector load triggers descriptor fetch and install
// - descriptors written only by internal load logic
// - loaded segment translates with no table access
// - fetch uses ip in code, stack uses sp
// - implicit segment from instruction type
// - override prefix forces the segment of the next translation when it is a data access
// - offset is base plus scaled index plus displacement
// - base, index from any register; displacement from instruction
// - index scaled by one, two, four, eight
// - displacement 8 or 32 bits, sign extended
// - seven memory modes; register, immediate need none
// - zero base descriptors give one flat space
// - unaligned operands accepted, flagged for extra cycles
// - near pointer 32 bits, far pointer 48 bits
// - logical address is 16-bit selector plus offset
// - address is descriptor base plus offset
package lag_pkg;
	localparam int ADDR_W = 32;
	localparam int SEL_W  = 16;
	localparam int FAR_W  = 48;
	localparam int NSEG   = 6;
	localparam int SEGI_W = 3;
	localparam int NGPR   = 8;
	localparam int GPR_W  = 3;
	// segment indices
	localparam logic [2:0] SEG_CODE   = 3'h0;
	localparam logic [2:0] SEG_STACK  = 3'h1;
	localparam logic [2:0] SEG_DATA_A = 3'h2;
	localparam logic [2:0] SEG_DATA_B = 3'h3;
	localparam logic [2:0] SEG_DATA_C = 3'h4;
	localparam logic [2:0] SEG_DATA_D = 3'h5;
	// reset base of every descriptor: flat space
	localparam logic [31:0] DESC_BASE_RST = 32'h0000_0000;
	localparam logic [15:0] SEL_RST       = 16'h0000;
	// access class from the decoder
	typedef enum logic [1:0] {
		ACC_FETCH = 2'h0,
		ACC_STACK = 2'h1,
		ACC_DATA  = 2'h2,
		ACC_JUMP  = 2'h3
	} acc_kind_t;
	// operand sizes in bytes, encoded log2 except SZ_FAR, the 6-byte far pointer
	typedef enum logic [1:0] {
		SZ_BYTE  = 2'h0,
		SZ_WORD  = 2'h1,
		SZ_DWORD = 2'h2,
		SZ_FAR   = 2'h3
	} op_size_t;
	// descriptor load controller states
	typedef enum logic [2:0] {
		LD_IDLE = 3'b001,
		LD_REQ  = 3'b010,
		LD_WAIT = 3'b100
	} ld_state_t;
endpackage

/* core/offset_if.sv */
// bundle between translator and offset adder
`timescale 1ns/100ps
`default_nettype none
interface offset_if;
	import lag_pkg::*;
	logic [31:0] base_val;
	logic [31:0] index_val;
	logic [1:0]  scale_log;
	logic [31:0] disp_val;
	logic        disp_wide;
	logic        use_base;
	logic        use_index;
	logic        use_disp;
	logic [31:0] offset;
	modport src (output base_val, index_val, scale_log, disp_val, disp_wide,
		use_base, use_index, use_disp, input offset);
	modport calc (input base_val, index_val, scale_log, disp_val, disp_wide,
		use_base, use_index, use_disp, output offset);
endinterface
`default_nettype wire

/* core/offset_adder.sv */
// combinational effective offset adder
`timescale 1ns/100ps
`default_nettype none
module offset_adder
	import lag_pkg::*;
(
	offset_if.calc oi
);
	logic [31:0] base_term;
	logic [31:0] index_term;
	logic [31:0] disp_term;
	// absent parts contribute zero; scale by shift; narrow disp sign extended
	always_comb begin
		base_term  = oi.use_base ? oi.base_val : 32'h0000_0000;
		index_term = oi.use_index ? (oi.index_val << oi.scale_log) : 32'h0000_0000;
		if (!oi.use_disp) begin
			disp_term = 32'h0000_0000;
		end else if (oi.disp_wide) begin
			disp_term = oi.disp_val;
		end else begin
			disp_term = {{24{oi.disp_val[7]}}, oi.disp_val[7:0]};
		end
		oi.offset = 32'(base_term + index_term + disp_term);
	end
endmodule
`default_nettype wire

/* sim/desc_bus_model.sv */
// descriptor fetch responder standing in for the bus unit
`timescale 1ns/100ps
`default_nettype none
module desc_bus_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic [15:0] sel_i,
	input  wire logic [3:0]  lat_i,
	output logic             ack_o,
	output logic [31:0]      base_o
);
	logic [3:0]  cnt = 4'h0;
	initial ack_o = 1'b0;
	// one ack pulse after lat_i waiting cycles
	always @(posedge clk_i) begin
		cnt <= (req_i && !ack_o) ? cnt + 4'h1 : 4'h0;
		ack_o <= req_i && !ack_o && cnt >= lat_i;
	end
	// base is the selector twice; its inverse when not answering
	assign base_o = ack_o ? {sel_i, sel_i} : ~{sel_i, sel_i};
endmodule
`default_nettype wire

/* sim/lag_properties.sv */
// port checker for the logical address generator
`timescale 1ns/100ps
`default_nettype none
module lag_properties
	import lag_pkg::*;
(
	input wire logic        core_clk_i,
	input wire logic        srst_i,
	input wire logic        sel_wr_i,
	input wire logic [2:0]  sel_wr_idx_i,
	input wire logic [15:0] sel_wr_val_i,
	input wire logic        desc_req_o,
	input wire logic [15:0] desc_sel_o,
	input wire logic        desc_ack_i,
	input wire logic        load_busy_o,
	input wire logic        xlat_req_i,
	input wire op_size_t    op_size_i,
	input wire logic        addr_vld_o,
	input wire logic [31:0] near_ptr_o,
	input wire logic [47:0] far_ptr_o,
	input wire logic        misaligned_o,
	input wire logic [15:0] data_segment_selector_a_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// selector write accepted, then busy and fetch request
	sequence s_take; sel_wr_i && !load_busy_o; endsequence
	sequence s_load; ##1 load_busy_o ##1 desc_req_o; endsequence
	sequence s_xl; xlat_req_i && !load_busy_o && !sel_wr_i; endsequence
	property p_load; s_take |-> s_load; endproperty
	property p_sel; s_take |-> ##2 desc_sel_o == $past(sel_wr_val_i, 2); endproperty
	property p_hold; desc_req_o && !desc_ack_i |=> desc_req_o; endproperty
	property p_done; desc_req_o && desc_ack_i |=> !desc_req_o && !load_busy_o; endproperty
	property p_cache; desc_req_o |-> load_busy_o; endproperty
	property p_sela;
		s_take and sel_wr_idx_i == SEG_DATA_A |=> data_segment_selector_a_o == $past(sel_wr_val_i);
	endproperty
	property p_vld; s_xl |=> addr_vld_o; endproperty
	property p_novld; !(xlat_req_i && !load_busy_o && !sel_wr_i) |=> !addr_vld_o; endproperty
	property p_far; addr_vld_o |-> far_ptr_o[31:0] == near_ptr_o; endproperty
	property p_nofetch; s_xl |=> !desc_req_o && !load_busy_o; endproperty
	property p_mis;
		addr_vld_o |-> misaligned_o == |(near_ptr_o[1:0] & ($past(op_size_i) == SZ_DWORD ? 2'h3 :
			$past(op_size_i) == SZ_BYTE ? 2'h0 : 2'h1));
	endproperty
	a_load: assert property (p_load) else $error("load steps wrong");
	a_sel: assert property (p_sel) else $error("fetch selector wrong");
	a_hold: assert property (p_hold) else $error("request dropped early");
	a_done: assert property (p_done) else $error("load not ended");
	a_cache: assert property (p_cache) else $error("fetch outside a load");
	a_sela: assert property (p_sela) else $error("selector not held");
	a_vld: assert property (p_vld) else $error("no address pulse");
	a_novld: assert property (p_novld) else $error("stray address pulse");
	a_far: assert property (p_far) else $error("far offset wrong");
	a_nofetch: assert property (p_nofetch) else $error("fetch during translation");
	a_mis: assert property (p_mis) else $error("alignment flag wrong");
endmodule
bind logical_address_generation lag_properties u_props (.core_clk_i, .srst_i, .sel_wr_i,
	.sel_wr_idx_i, .sel_wr_val_i, .desc_req_o, .desc_sel_o, .desc_ack_i, .load_busy_o,
	.xlat_req_i, .op_size_i, .addr_vld_o, .near_ptr_o, .far_ptr_o, .misaligned_o,
	.data_segment_selector_a_o);
`default_nettype wire

/* sim/logical_address_generation_tb_top.sv */
// self-checking bench for the logical address generator
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module logical_address_generation_tb_top;
	import lag_pkg::*;
	logic core_clk_i = 1'b0, srst_i = 1'b1, sel_wr_i = 1'b0, prefix_i = 1'b0, xlat_req_i = 1'b0;
	logic use_base_i = 1'b0, use_index_i = 1'b0, use_disp_i = 1'b0, disp_wide_i = 1'b0;
	logic [2:0] sel_wr_idx_i = 3'h0, prefix_seg_i = 3'h0, base_sel_i = 3'h0, index_sel_i = 3'h0;
	logic [1:0] scale_log_i = 2'h0;
	logic [15:0] sel_wr_val_i = 16'h0000, desc_sel_o, data_segment_selector_a_o;
	logic [31:0] instruction_pointer_reg_i = 32'h0000_1003, stack_pointer_reg_i = 32'h0000_2ffc;
	logic [31:0] disp_i = 32'h0000_0000, desc_base_i, addr_o, near_ptr_o;
	logic [255:0] gpr_i;
	acc_kind_t acc_kind_i = ACC_DATA;
	op_size_t op_size_i = SZ_DWORD;
	logic desc_ack_i, desc_req_o, load_busy_o, addr_vld_o, misaligned_o;
	logic [47:0] far_ptr_o;
	logic [2:0] seg_used_o;
	logic [3:0] lat = 4'h2;
	int n_fail = 0;
	int n_compared = 0;
	always #10 core_clk_i = ~core_clk_i;
	logical_address_generation dut (.core_clk_i, .srst_i, .sel_wr_i, .sel_wr_idx_i, .sel_wr_val_i,
		.desc_req_o, .desc_sel_o, .desc_ack_i, .desc_base_i, .load_busy_o, .gpr_i,
		.instruction_pointer_reg_i, .stack_pointer_reg_i, .prefix_i, .prefix_seg_i, .xlat_req_i,
		.acc_kind_i, .op_size_i, .use_base_i, .base_sel_i, .use_index_i, .index_sel_i,
		.scale_log_i, .use_disp_i, .disp_wide_i, .disp_i, .addr_vld_o, .addr_o, .near_ptr_o,
		.far_ptr_o, .seg_used_o, .misaligned_o, .data_segment_selector_a_o,
		.data_segment_selector_b_o(), .data_segment_selector_c_o(), .data_segment_selector_d_o());
	desc_bus_model bus (.clk_i(core_clk_i), .req_i(desc_req_o), .sel_i(desc_sel_o), .lat_i(lat),
		.ack_o(desc_ack_i), .base_o(desc_base_i));
	function automatic logic [31:0] g(int n);
		return 32'h1111_1111 * (n + 1);
	endfunction
	// one translation request, answer expected next cycle
	task automatic fx(acc_kind_t k, logic ub, logic [2:0] bs, logic ui, logic [2:0] is,
		logic [1:0] sc, logic ud, logic dw, logic [31:0] d);
		acc_kind_i = k;
		{use_base_i, base_sel_i, use_index_i, index_sel_i} = {ub, bs, ui, is};
		{scale_log_i, use_disp_i, disp_wide_i, disp_i, xlat_req_i} = {sc, ud, dw, d, 1'b1};
		@(posedge core_clk_i) #1 xlat_req_i = 1'b0;
		`CHK("addr_vld", 1'b1, addr_vld_o)
		@(posedge core_clk_i) #1;
		`CHK("vld_pulse", 1'b0, addr_vld_o)
	endtask
	// selector load; probe tries a translation with the write and while busy
	task automatic ld(logic [2:0] idx, logic [15:0] v, logic probe);
		{sel_wr_i, sel_wr_idx_i, sel_wr_val_i, xlat_req_i} = {1'b1, idx, v, probe};
		@(posedge core_clk_i) #1 sel_wr_i = 1'b0;
		`CHK("refused_wr", 1'b0, addr_vld_o)
		@(posedge core_clk_i) #1 xlat_req_i = 1'b0;
		`CHK("refused", 1'b0, addr_vld_o)
		for (int i = 0; i < 40 && load_busy_o; i++) @(posedge core_clk_i) #1;
		`CHK("load_busy", 1'b0, load_busy_o)
	endtask
	task automatic t_flat();
		logic [31:0] e;
		e = g(1) + (g(7) << 3) + 32'hffff_ff80;
		fx(ACC_DATA, 1'b1, 3'h1, 1'b1, 3'h7, 2'h3, 1'b1, 1'b0, 32'h1234_5680);
		`CHK("flat", e, addr_o)
		`CHK("mis", |e[1:0], misaligned_o)
	endtask
	task automatic t_modes();
		logic [31:0] e;
		for (int m = 1; m < 8; m++) begin
			e = (m[2] ? g(m) : 32'h0) + (m[1] ? g(7 - m) << 2'(m + m[2]) : 32'h0);
			e = e + (m[0] ? 32'h8000_0010 : 32'h0);
			fx(ACC_DATA, m[2], m[2:0], m[1], 3'(7 - m), 2'(m + m[2]), m[0], 1'b1, 32'h8000_0010);
			`CHK("offset", e, near_ptr_o)
		end
	endtask
	task automatic t_implicit();
		op_size_i = SZ_BYTE;
		fx(ACC_FETCH, 1'b0, 3'h0, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0, 32'h0);
		`CHK("fetch", {SEG_CODE, 32'h0000_1003}, {seg_used_o, addr_o})
		`CHK("mis_byte", 1'b0, misaligned_o)
		op_size_i = SZ_FAR;
		fx(ACC_STACK, 1'b0, 3'h0, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0, 32'h0);
		`CHK("stack", {SEG_STACK, 32'h0000_2ffc}, {seg_used_o, addr_o})
		`CHK("mis_far", 1'b0, misaligned_o)
		op_size_i = SZ_WORD;
		fx(ACC_JUMP, 1'b0, 3'h0, 1'b0, 3'h0, 2'h0, 1'b1, 1'b1, 32'h0000_0401);
		`CHK("jump", {SEG_CODE, 32'h0000_0401}, {seg_used_o, addr_o})
		`CHK("mis_word", 1'b1, misaligned_o)
		op_size_i = SZ_DWORD;
	endtask
	task automatic t_load();
		lat = 4'h5;
		ld(SEG_DATA_A, 16'ha5c3, 1'b1);
		`CHK("sel_a", 16'ha5c3, data_segment_selector_a_o)
		fx(ACC_DATA, 1'b0, 3'h0, 1'b0, 3'h0, 2'h0, 1'b1, 1'b1, 32'h0000_0100);
		`CHK("addr", {SEG_DATA_A, 32'ha5c3_a6c3}, {seg_used_o, addr_o})
		`CHK("far", 48'ha5c3_0000_0100, far_ptr_o)
		`CHK("req", 1'b0, desc_req_o)
	endtask
	task automatic t_prefix();
		lat = 4'h0;
		prefix_seg_i = SEG_DATA_B;
		prefix_i = 1'b1;
		@(posedge core_clk_i) #1 prefix_i = 1'b0;
		// refused translations during the load must leave the prefix pending
		ld(SEG_DATA_B, 16'h0f0f, 1'b1);
		fx(ACC_DATA, 1'b0, 3'h0, 1'b0, 3'h0, 2'h0, 1'b1, 1'b1, 32'h0000_0010);
		`CHK("override", {SEG_DATA_B, 32'h0f0f_0f1f}, {seg_used_o, addr_o})
		fx(ACC_DATA, 1'b0, 3'h0, 1'b0, 3'h0, 2'h0, 1'b1, 1'b1, 32'h0000_0010);
		`CHK("implicit", {SEG_DATA_A, 32'ha5c3_a5d3}, {seg_used_o, addr_o})
	endtask
	// mid-run reset: selectors cleared, descriptors back to flat
	task automatic t_reset();
		srst_i = 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1 srst_i = 1'b0;
		`CHK("sel_a_rst", SEL_RST, data_segment_selector_a_o)
		fx(ACC_DATA, 1'b0, 3'h0, 1'b0, 3'h0, 2'h0, 1'b1, 1'b1, 32'h0000_0010);
		`CHK("flat_rst", {SEG_DATA_A, 32'h0000_0010}, {seg_used_o, addr_o})
		`CHK("far_rst", {SEL_RST, 32'h0000_0010}, far_ptr_o)
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		for (int n = 0; n < 8; n++) gpr_i[n*32 +: 32] = g(n);
		repeat (8) @(posedge core_clk_i);
		#1 srst_i = 1'b0;
		t_flat();
		t_modes();
		t_implicit();
		t_load();
		t_prefix();
		t_reset();
		print_verdict();
	end
	// watchdog well beyond the fifty-odd cycles needed
	initial begin
		repeat (2000) @(posedge core_clk_i);
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire
